// File: jie_map.svh
`ifndef JIE_MAP_SVH
`define JIE_MAP_SVH
// How it works
// R1 - programming enters through the 1532 test port
// R2 - no programming step while in sleep mode
// R3 - programmer wakes the device before commands
// R4 - unprogrammed device keeps pad enable inactive
// R5 - inactive pad enable also blocks input buffers
// R6 - sample/preload captures pads, shifts, stages bits
// R7 - input cells capture defined pin values
// R8 - drivers stay off while pad enable inactive

// ----------------------------------------------------------
// instruction register
// ----------------------------------------------------------
`define JIE_IR_LEN       8
`define JIE_IR_CAP       8'h01
`define JIE_IR_RST       8'hff
`define JIE_OP_BYPASS    8'hff
`define JIE_OP_SAMPLE    8'h01
`define JIE_OP_PROG_EN   8'h0b
`define JIE_OP_PROG_WORD 8'h0c
`define JIE_OP_PROG_DIS  8'h0d

// ----------------------------------------------------------
// sizes and cell layout
// ----------------------------------------------------------
`define JIE_PADS         4
`define JIE_PROG_W       16
`define JIE_CELLS        3
`define JIE_CELL_IN      0
`define JIE_CELL_OUT     1
`define JIE_CELL_OE      2

// ----------------------------------------------------------
// test pin sync bit positions
// ----------------------------------------------------------
`define JIE_SY_TCK       0
`define JIE_SY_TMS       1
`define JIE_SY_TDI       2
`define JIE_SY_TRST      3
`endif

// File: jie_pkg.sv
package jie_pkg;
   // test access port controller states
   typedef enum logic [3:0] {
      TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
      SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
   } jie_tap_t;
endpackage : jie_pkg

// File: jie_bsc.sv
`timescale 1ns/1ps
`include "jie_map.svh"
// ----------------------------------------------------------
// boundary_scan_chain: three cells per pad
// ----------------------------------------------------------
module jie_bsc #(
   parameter int PADS = `JIE_PADS
) (
   input  wire logic            clk,
   input  wire logic            nrst,
   input  wire logic            capture,  // parallel load of pads
   input  wire logic            shift,    // one step toward so
   input  wire logic            update,   // stage shifted bits
   input  wire logic            si,
   input  wire logic [PADS-1:0] pin,      // synced pad levels
   input  wire logic [PADS-1:0] core_out,
   input  wire logic [PADS-1:0] core_oe,
   output logic                 so,
   output logic [`JIE_CELLS*PADS-1:0] staged
);
   localparam int NC = `JIE_CELLS * PADS;

   typedef struct packed {
      logic [NC-1:0] sh;    // shift stage
      logic [NC-1:0] upd;   // staged preload bits
   } jie_bsc_t;

   jie_bsc_t      st;
   jie_bsc_t      next_st;
   logic [NC-1:0] cap_v;    // parallel capture image

   // ----------------------------------------------------------
   // capture image, one group per pad
   // ----------------------------------------------------------
   genvar k;
   generate
      for (k = 0; k < PADS; k++) begin : g_pad
         // input cell sees the real pin, so it is always defined
         assign cap_v[`JIE_CELLS*k+`JIE_CELL_IN]  = pin[k]; // see R7
         // output cells follow the fabric, undefined if unprogrammed
         assign cap_v[`JIE_CELLS*k+`JIE_CELL_OUT] = core_out[k];
         assign cap_v[`JIE_CELLS*k+`JIE_CELL_OE]  = core_oe[k];

         in_cell_a: assert property ( // see R7
            @(posedge clk) disable iff (!nrst)
            capture |=> st.sh[`JIE_CELLS*k] == $past(pin[k]))
            else $error("input cell lost pin level");
      end
   endgenerate

   // next state: capture wins over shift
   always_comb begin
      next_st = st;
      if (capture) begin
         next_st.sh = cap_v;                    // see R6
      end else if (shift) begin
         next_st.sh = {si, st.sh[NC-1:1]};      // see R6
      end
      if (update) begin
         next_st.upd = st.sh;                   // see R6
      end
   end

   // state register
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign so     = st.sh[0];
   assign staged = st.upd;

   shift_step_a: assert property ( // see R6
      @(posedge clk) disable iff (!nrst)
      shift && !capture |=> st.sh[NC-1] == $past(si)
         && st.sh[NC-2:0] == $past(st.sh[NC-1:1]))
      else $error("chain did not shift one place");
endmodule : jie_bsc

// File: jie_top.sv
`timescale 1ns/1ps
`include "jie_map.svh"
// ----------------------------------------------------------
// test port with in_system_programming entry and pad gating
// ----------------------------------------------------------
module jie_top #(
   parameter int PADS = `JIE_PADS,
   parameter int PW   = `JIE_PROG_W
) (
   input  wire logic            clk,
   input  wire logic            nrst,
   input  wire logic            tck,        // test clock pin
   input  wire logic            tms,
   input  wire logic            tdi,
   input  wire logic            trst_n,
   input  wire logic            sleep,      // low-power mode level
   input  wire logic            programmed, // configuration present
   input  wire logic [PADS-1:0] pad_in,     // pin input levels
   input  wire logic [PADS-1:0] core_out,   // fabric output data
   input  wire logic [PADS-1:0] core_oe,    // fabric output enable
   output logic                 tdo,
   output logic                 tdo_oe,
   output logic                 global_pad_enable,
   output logic [PADS-1:0]      pad_out,
   output logic [PADS-1:0]      pad_oe,
   output logic [PADS-1:0]      core_in,    // gated input buffers
   output logic                 in_system_programming,
   output logic                 prog_refused,
   output logic                 prog_strobe,
   output logic [PW-1:0]        prog_data,
   output logic [`JIE_CELLS*PADS-1:0] staged
);
   localparam int IRL = `JIE_IR_LEN;

   // ----------------------------------------------------------
   // state
   // ----------------------------------------------------------
   typedef struct packed {
      logic [3:0]        js1;     // test pins, first stage
      logic [3:0]        js2;
      logic [3:0]        js3;
      logic [3:0]        jf;      // agreed test pin levels
      logic [PADS-1:0]   ps1;     // pad inputs, first stage
      logic [PADS-1:0]   ps2;
      logic [PADS-1:0]   ps3;
      logic [PADS-1:0]   pf;      // agreed pad levels
      jie_pkg::jie_tap_t tap;
      logic [IRL-1:0]    ir_sh;   // instruction shift stage
      logic [IRL-1:0]    ir;      // active instruction
      logic              byp;
      logic [PW-1:0]     pg_sh;   // programming word shift
      logic [PW-1:0]     prog_data;
      logic              prog_mode;   // in_system_programming mode
      logic              refused;     // last entry refused, sticky
      logic              prog_strobe;
      logic              tdo;
      logic              tdo_oe;
      logic              gpe;
      logic [PADS-1:0]   pad_out;
      logic [PADS-1:0]   pad_oe;
      logic [PADS-1:0]   core_in;
   } jie_state_t;

   jie_state_t st;
   jie_state_t next_st;

   logic [3:0] jf_n;        // test pin levels after filtering
   logic       rise;        // tck rising edge seen
   logic       fall;        // tck falling edge seen
   logic       tms_v;
   logic       tdi_v;
   logic       trst_v;
   logic       sel_sample;  // sample/preload selects the chain
   logic       sel_prog;    // programming word selected
   logic       dr_so;
   logic       bs_cap;
   logic       bs_sh;
   logic       bs_upd;
   logic       bs_so;

   // ----------------------------------------------------------
   // controller step
   // ----------------------------------------------------------
   function automatic jie_pkg::jie_tap_t tap_next(
      input jie_pkg::jie_tap_t t,
      input logic              m
   );
      case (t)
         jie_pkg::TLR:    tap_next = m ? jie_pkg::TLR    : jie_pkg::RTI;
         jie_pkg::RTI:    tap_next = m ? jie_pkg::SEL_DR : jie_pkg::RTI;
         jie_pkg::SEL_DR: tap_next = m ? jie_pkg::SEL_IR : jie_pkg::CAP_DR;
         jie_pkg::CAP_DR: tap_next = m ? jie_pkg::EX1_DR : jie_pkg::SH_DR;
         jie_pkg::SH_DR:  tap_next = m ? jie_pkg::EX1_DR : jie_pkg::SH_DR;
         jie_pkg::EX1_DR: tap_next = m ? jie_pkg::UPD_DR : jie_pkg::PA_DR;
         jie_pkg::PA_DR:  tap_next = m ? jie_pkg::EX2_DR : jie_pkg::PA_DR;
         jie_pkg::EX2_DR: tap_next = m ? jie_pkg::UPD_DR : jie_pkg::SH_DR;
         jie_pkg::UPD_DR: tap_next = m ? jie_pkg::SEL_DR : jie_pkg::RTI;
         jie_pkg::SEL_IR: tap_next = m ? jie_pkg::TLR    : jie_pkg::CAP_IR;
         jie_pkg::CAP_IR: tap_next = m ? jie_pkg::EX1_IR : jie_pkg::SH_IR;
         jie_pkg::SH_IR:  tap_next = m ? jie_pkg::EX1_IR : jie_pkg::SH_IR;
         jie_pkg::EX1_IR: tap_next = m ? jie_pkg::UPD_IR : jie_pkg::PA_IR;
         jie_pkg::PA_IR:  tap_next = m ? jie_pkg::EX2_IR : jie_pkg::PA_IR;
         jie_pkg::EX2_IR: tap_next = m ? jie_pkg::UPD_IR : jie_pkg::SH_IR;
         jie_pkg::UPD_IR: tap_next = m ? jie_pkg::SEL_DR : jie_pkg::RTI;
         default:         tap_next = jie_pkg::TLR;
      endcase
   endfunction : tap_next

   // ----------------------------------------------------------
   // pin filtering and decode
   // ----------------------------------------------------------
   // a level counts once stages two and three agree
   assign jf_n   = (st.js2 & st.js3) | (st.jf & (st.js2 ^ st.js3));
   assign rise   = jf_n[`JIE_SY_TCK] & ~st.jf[`JIE_SY_TCK];
   assign fall   = ~jf_n[`JIE_SY_TCK] & st.jf[`JIE_SY_TCK];
   assign tms_v  = jf_n[`JIE_SY_TMS];
   assign tdi_v  = jf_n[`JIE_SY_TDI];
   assign trst_v = jf_n[`JIE_SY_TRST];

   assign sel_sample = (st.ir == `JIE_OP_SAMPLE);
   assign sel_prog   = (st.ir == `JIE_OP_PROG_WORD) && st.prog_mode;
   assign dr_so = sel_sample ? bs_so : (sel_prog ? st.pg_sh[0] : st.byp);

   // chain steps only on tck edges with sample/preload loaded
   assign bs_cap = rise && sel_sample && st.tap == jie_pkg::CAP_DR;
   assign bs_sh  = rise && sel_sample && st.tap == jie_pkg::SH_DR;
   assign bs_upd = rise && sel_sample && st.tap == jie_pkg::UPD_DR;

   // ----------------------------------------------------------
   // next state
   // ----------------------------------------------------------
   always_comb begin
      next_st     = st;
      next_st.js1 = {trst_n, tdi, tms, tck};
      next_st.js2 = st.js1;
      next_st.js3 = st.js2;
      next_st.jf  = jf_n;
      next_st.ps1 = pad_in;
      next_st.ps2 = st.ps1;
      next_st.ps3 = st.ps2;
      next_st.pf  = (st.ps2 & st.ps3) | (st.pf & (st.ps2 ^ st.ps3));
      next_st.prog_strobe = 1'b0;
      if (!trst_v) begin
         // test reset leaves programming mode at once
         next_st.tap         = jie_pkg::TLR;
         next_st.ir          = `JIE_IR_RST;
         next_st.prog_mode   = 1'b0;                    // see R1
         next_st.refused     = 1'b0;
      end else if (rise) begin
         next_st.tap = tap_next(st.tap, tms_v);         // see R1
         case (st.tap)
            jie_pkg::TLR: begin
               next_st.ir        = `JIE_IR_RST;
               next_st.prog_mode = 1'b0;
            end
            jie_pkg::CAP_IR: begin
               next_st.ir_sh = `JIE_IR_CAP;
            end
            jie_pkg::SH_IR: begin
               next_st.ir_sh = {tdi_v, st.ir_sh[IRL-1:1]};
            end
            jie_pkg::UPD_IR: begin
               next_st.ir = st.ir_sh;
               if (st.ir_sh == `JIE_OP_PROG_EN) begin
                  // entry refused while asleep; programmer must wake us
                  if (sleep) begin
                     next_st.refused   = 1'b1;          // see R2, R3
                  end else begin
                     next_st.prog_mode = 1'b1;          // see R1
                     next_st.refused   = 1'b0;
                  end
               end else if (st.ir_sh == `JIE_OP_PROG_DIS) begin
                  next_st.prog_mode = 1'b0;             // see R1
               end
            end
            jie_pkg::CAP_DR: begin
               next_st.byp   = 1'b0;
               next_st.pg_sh = st.prog_data;
            end
            jie_pkg::SH_DR: begin
               next_st.byp   = tdi_v;
               next_st.pg_sh = {tdi_v, st.pg_sh[PW-1:1]};
            end
            jie_pkg::UPD_DR: begin
               // a word loaded while asleep is dropped, not queued
               if (sel_prog && !sleep) begin
                  next_st.prog_data   = st.pg_sh;       // see R2
                  next_st.prog_strobe = 1'b1;           // see R2
               end
            end
            default: begin
            end
         endcase
      end else if (fall) begin
         // tdo moves on the falling edge, driven only while shifting
         next_st.tdo_oe = (st.tap == jie_pkg::SH_DR)
                       || (st.tap == jie_pkg::SH_IR);
         next_st.tdo = (st.tap == jie_pkg::SH_IR) ? st.ir_sh[0]
                                                  : dr_so; // see R6
      end
      // pins isolated when unprogrammed and during programming
      next_st.gpe     = programmed && !st.prog_mode;     // see R4
      next_st.pad_out = st.gpe ? core_out : '0;          // see R8
      next_st.pad_oe  = st.gpe ? core_oe  : '0;          // see R8
      next_st.core_in = st.gpe ? st.pf    : '0;          // see R5
   end

   // ----------------------------------------------------------
   // state register
   // ----------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st       <= '0;
         st.tap   <= jie_pkg::TLR;
         st.ir    <= `JIE_IR_RST;
         st.ir_sh <= `JIE_IR_RST;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------
   // boundary_scan_chain
   // ----------------------------------------------------------
   jie_bsc #(
      .PADS     (PADS)
   ) u_bsc (
      .clk      (clk),
      .nrst     (nrst),
      .capture  (bs_cap),
      .shift    (bs_sh),
      .update   (bs_upd),
      .si       (tdi_v),
      .pin      (st.pf),
      .core_out (core_out),
      .core_oe  (core_oe),
      .so       (bs_so),
      .staged   (staged)
   );

   assign tdo               = st.tdo;
   assign tdo_oe            = st.tdo_oe;
   assign global_pad_enable = st.gpe;
   assign pad_out           = st.pad_out;
   assign pad_oe            = st.pad_oe;
   assign core_in           = st.core_in;
   assign in_system_programming = st.prog_mode;
   assign prog_refused      = st.refused;
   assign prog_strobe       = st.prog_strobe;
   assign prog_data         = st.prog_data;

   // ----------------------------------------------------------
   // checks
   // ----------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   sequence enable_step;
      trst_v && rise && st.tap == jie_pkg::UPD_IR
         && st.ir_sh == `JIE_OP_PROG_EN;
   endsequence

   sequence prog_step;
      trst_v && rise && st.tap == jie_pkg::UPD_DR && sel_prog;
   endsequence

   prog_entry_a: assert property ( // see R1
      enable_step and !sleep |=> in_system_programming && !prog_refused)
      else $error("awake enable did not enter programming");
   entry_refuse_a: assert property ( // see R2
      enable_step and sleep |=> prog_refused
         && in_system_programming == $past(st.prog_mode))
      else $error("enable during sleep not refused");
   sleep_block_a: assert property (sleep |=> !prog_strobe) // see R2
      else $error("programming strobe while asleep");
   prog_word_a: assert property ( // see R1
      prog_step and !sleep
      |=> prog_strobe && prog_data == $past(st.pg_sh) ##1 !prog_strobe)
      else $error("programming word not delivered once");
   gate_off_a: assert property ( // see R4
      !programmed |=> !global_pad_enable ##1 pad_oe == '0)
      else $error("pad enable active while unprogrammed");
   in_buf_a: assert property (!global_pad_enable |=> core_in == '0) // see R5
      else $error("input buffer open while pads disabled");
   out_hiz_a: assert property ( // see R8
      !global_pad_enable |=> pad_oe == '0 && pad_out == '0)
      else $error("driver on while pads disabled");
   tdo_chain_a: assert property ( // see R6
      trst_v && fall && sel_sample && st.tap == jie_pkg::SH_DR
      |=> tdo == $past(bs_so) && tdo_oe)
      else $error("chain bit not presented on tdo");
   trst_a: assert property ( // see R1
      !trst_v |=> !in_system_programming && st.tap == jie_pkg::TLR)
      else $error("test reset did not clear programming");
endmodule : jie_top

// File: jie_prog_model.sv
`timescale 1ns/1ps
// --------------------
// programmer model on the test pins
// --------------------
module jie_prog_model (
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   output logic      trst_n,
   input  wire logic tdo,
   input  wire logic sleep
);
   localparam time HALF = 400ns;  // 800 ns test clock period

   // idle levels: clock parked low, pulled-up lines high
   initial begin
      tck    = 1'b0;
      tms    = 1'b1;
      tdi    = 1'b1;
      trst_n = 1'b1;
   end

   // one test clock; tdo read late in the high phase because the
   // device only shows it a few system clocks after our fall
   task automatic step(input logic m, input logic d, output logic q);
      tms = m;
      tdi = d;
      #(HALF) tck = 1'b1;
      #(HALF - 10ns) q = tdo;
      #10ns tck = 1'b0;
   endtask : step

   // five ones reach reset from any state, then park in idle
   task automatic reset_tap();
      logic q;
      repeat (5) step(1'b1, 1'b1, q);
      step(1'b0, 1'b1, q);
   endtask : reset_tap

   // test reset pin pulse, long enough for the input filter
   task automatic pulse_trst();
      trst_n = 1'b0;
      #1000ns trst_n = 1'b1;
      #500ns;
   endtask : pulse_trst

   // full scan from idle back to idle, lsb first; rude skips the
   // wait for wake-up so a refusal can be provoked on purpose
   task automatic scan(input logic ir, input int n,
                       input logic [15:0] din, input logic rude,
                       output logic [15:0] dout);
      logic q;
      int   w;
      dout = '0;
      w = 0;
      while (sleep === 1'b1 && !rude && w < 1000) begin
         #100ns;
         w++;
      end
      step(1'b1, 1'b1, q);            // select data path
      if (ir) begin
         step(1'b1, 1'b1, q);         // select instruction path
      end
      step(1'b0, 1'b1, q);            // capture
      step(1'b0, 1'b1, q);            // enter shift
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], q);
         dout[i] = q;
      end
      step(1'b1, 1'b1, q);            // update
      step(1'b0, 1'b1, q);            // back to idle
      tdi = 1'b1;                     // released: pull-up level
   endtask : scan
endmodule : jie_prog_model

// File: test_jtag_isp_entry_io_gating.sv
`timescale 1ns/1ps
// --------------------
// bench for test port, programming entry and pad gating
// --------------------
module test_jtag_isp_entry_io_gating;
   localparam int PADS = 4;
   localparam int PW   = 16;
   logic            clk, nrst, sleep, programmed;
   logic            tck, tms, tdi, trst_n, tdo, tdo_oe;
   logic            gpe, in_system_programming, prog_refused;
   logic            prog_strobe;
   logic [PADS-1:0] pad_in, core_out, core_oe, pad_out, pad_oe, core_in;
   logic [PW-1:0]   prog_data;
   logic [3*PADS-1:0] staged;
   logic [15:0]     d;
   int              miscompares = 0;
   int              samples_checked = 0;
   int              strobes = 0;  // programming words seen
   int              s0;

   jie_top #(.PADS(PADS), .PW(PW)) u_dut (
      .clk(clk), .nrst(nrst), .tck(tck), .tms(tms), .tdi(tdi),
      .trst_n(trst_n), .sleep(sleep), .programmed(programmed),
      .pad_in(pad_in), .core_out(core_out), .core_oe(core_oe),
      .tdo(tdo), .tdo_oe(tdo_oe), .global_pad_enable(gpe),
      .pad_out(pad_out), .pad_oe(pad_oe), .core_in(core_in),
      .in_system_programming(in_system_programming),
      .prog_refused(prog_refused),
      .prog_strobe(prog_strobe), .prog_data(prog_data),
      .staged(staged));

   jie_prog_model u_prog (
      .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo),
      .sleep(sleep));

   // --------------------
   // clock, strobe counter, helpers
   // --------------------
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // strobe is one clock wide, so count it at each edge
   always @(posedge clk) begin
      if (prog_strobe === 1'b1) begin
         strobes <= strobes + 1;
      end
   end

   // inputs move a fixed 2 ns after the edge
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask : tick

   task automatic chk(input string what, input logic [15:0] exp,
                      input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : test_done

   // --------------------
   // scenarios
   // --------------------
   // unprogrammed pads stay dark even with busy fabric
   task automatic t_gate();
      pad_in   = 4'hf;
      core_out = 4'h3;
      core_oe  = 4'h5;
      tick(8);
      chk("pad enable", 16'h0, gpe);
      chk("pad_oe", 16'h0, pad_oe);
      chk("pad_out", 16'h0, pad_out);
      chk("core_in", 16'h0, core_in);
      chk("tdo_oe", 16'h0, tdo_oe);
      programmed = 1'b1;
      tick(8);
      chk("pad enable on", 16'h1, gpe);
      chk("pad_oe on", 16'h5, pad_oe);
      chk("pad_out on", 16'h3, pad_out);
      chk("core_in on", 16'hf, core_in);
   endtask : t_gate

   // enable refused asleep, then enable, program, disable
   task automatic t_program();
      sleep = 1'b1;
      u_prog.reset_tap();
      u_prog.scan(1'b1, 8, 16'h0b, 1'b1, d);
      chk("ir capture", 16'h01, d);
      tick(4);
      chk("refused", 16'h1, prog_refused);
      chk("active asleep", 16'h0, in_system_programming);
      sleep = 1'b0;
      u_prog.scan(1'b1, 8, 16'h0b, 1'b0, d);
      tick(4);
      chk("active", 16'h1, in_system_programming);
      chk("refused cleared", 16'h0, prog_refused);
      chk("pad enable prog", 16'h0, gpe);
      chk("pad_oe prog", 16'h0, pad_oe);
      chk("core_in prog", 16'h0, core_in);
      u_prog.scan(1'b1, 8, 16'h0c, 1'b0, d);
      s0 = strobes;
      u_prog.scan(1'b0, PW, 16'ha5c3, 1'b0, d);
      tick(4);
      chk("strobes", 16'(1), 16'(strobes - s0));
      chk("prog_data", 16'ha5c3, prog_data);
      sleep = 1'b1;
      u_prog.scan(1'b0, PW, 16'h5a3c, 1'b1, d);
      chk("dr capture", 16'ha5c3, d);
      tick(4);
      chk("strobes asleep", 16'(1), 16'(strobes - s0));
      chk("data asleep", 16'ha5c3, prog_data);
      sleep = 1'b0;
      u_prog.scan(1'b1, 8, 16'h0d, 1'b0, d);
      tick(4);
      chk("disabled", 16'h0, in_system_programming);
      chk("pad enable back", 16'h1, gpe);
      u_prog.scan(1'b1, 8, 16'h0b, 1'b0, d);
      u_prog.pulse_trst();
      tick(4);
      chk("trst exit", 16'h0, in_system_programming);
   endtask : t_program

   // sample/preload, unprogrammed then programmed
   task automatic t_sample(input logic prg);
      logic [15:0] m;
      logic [15:0] e;
      programmed = prg;
      pad_in     = 4'h6;
      core_out   = 4'h9;
      core_oe    = 4'h3;
      m = '0;
      e = '0;
      for (int k = 0; k < PADS; k++) begin
         m[3*k] = 1'b1;
         e[3*k] = pad_in[k];
         e[3*k+1] = core_out[k];
         e[3*k+2] = core_oe[k];
         m[3*k+1] = prg;
         m[3*k+2] = prg;
      end
      tick(8);
      // five tms ones reset the port, then it is parked in idle, not reset
      u_prog.reset_tap();
      u_prog.scan(1'b1, 8, 16'h01, 1'b0, d);
      u_prog.scan(1'b0, 3*PADS, 16'h05a6, 1'b0, d);
      tick(4);
      chk("chain capture", e & m, d & m);
      chk("staged", 16'h05a6, 16'(staged));
      chk("pad_oe sample", {12'h0, core_oe & {PADS{prg}}}, 16'(pad_oe));
   endtask : t_sample

   // --------------------
   // main sequence and watchdog
   // --------------------
   initial begin
      nrst       = 1'b0;
      sleep      = 1'b0;
      programmed = 1'b0;
      pad_in     = '0;
      core_out   = '0;
      core_oe    = '0;
      repeat (8) @(posedge clk);
      #2 nrst = 1'b1;
      tick(4);
      t_gate();
      t_program();
      t_sample(1'b0);
      t_sample(1'b1);
      test_done();
   end

   // whole run needs well under 10000 clocks
   initial begin
      #3_000_000;
      miscompares++;
      $display("watchdog expired");
      test_done();
   end
endmodule : test_jtag_isp_entry_io_gating
